// ===== esn_pkg.sv
/*
 * Constants for the event selection and notification block.
 * Assumes a single 100 MHz clock domain.
 */
package esn_pkg;
    // ==========================================================
    // Event type codes (selector values)
    localparam int ESN_NUM_EVT = 41;
    localparam int ESN_SEL_W = 6;
    localparam logic [5:0] EV_ACQ_TRIG = 6'h00;
    localparam logic [5:0] EV_ACQ_BEGIN = 6'h01;
    localparam logic [5:0] EV_ACQ_FINISH = 6'h02;
    localparam logic [5:0] EV_ACQ_XFER_BEGIN = 6'h03;
    localparam logic [5:0] EV_ACQ_XFER_FINISH = 6'h04;
    localparam logic [5:0] EV_ACQ_FAULT = 6'h05;
    localparam logic [5:0] EV_IMG_TRIG = 6'h06;
    localparam logic [5:0] EV_IMG_BEGIN = 6'h07;
    localparam logic [5:0] EV_IMG_FINISH = 6'h08;
    localparam logic [5:0] EV_BURST_BEGIN = 6'h09;
    localparam logic [5:0] EV_BURST_FINISH = 6'h0a;
    localparam logic [5:0] EV_IMG_XFER_BEGIN = 6'h0b;
    localparam logic [5:0] EV_IMG_XFER_FINISH = 6'h0c;
    localparam logic [5:0] EV_EXPO_BEGIN = 6'h0d;
    localparam logic [5:0] EV_EXPO_FINISH = 6'h0e;
    localparam logic [5:0] EV_XFER_BEGIN = 6'h0f;
    localparam logic [5:0] EV_XFER_FINISH = 6'h10;
    localparam logic [5:0] EV_XFER_SUSPEND = 6'h11;
    localparam logic [5:0] EV_XFER_CONTINUE = 6'h12;
    localparam logic [5:0] EV_BLK_BEGIN = 6'h13;
    localparam logic [5:0] EV_BLK_FINISH = 6'h14;
    localparam logic [5:0] EV_BLK_TRIG = 6'h15;
    localparam logic [5:0] EV_XBURST_BEGIN = 6'h16;
    localparam logic [5:0] EV_XBURST_FINISH = 6'h17;
    localparam logic [5:0] EV_QUEUE_OVF = 6'h18;
    // Counters and timers: base + unit index
    localparam logic [5:0] EV_CNT_BEGIN0 = 6'h19;
    localparam logic [5:0] EV_CNT_FINISH0 = 6'h1b;
    localparam logic [5:0] EV_TMR_BEGIN0 = 6'h1d;
    localparam logic [5:0] EV_TMR_FINISH0 = 6'h1f;
    // Input lines: base + line index
    localparam logic [5:0] EV_IN_RISE0 = 6'h21;
    localparam logic [5:0] EV_IN_FALL0 = 6'h23;
    localparam logic [5:0] EV_IN_TOGGLE0 = 6'h25;
    localparam logic [5:0] EV_LATE_CMD = 6'h27;
    localparam logic [5:0] EV_LINK_RATE = 6'h28;
    localparam logic [5:0] EV_FAULT = 6'h29;
    localparam logic [5:0] EV_HANDOVER = 6'h2a;
    localparam int ESN_NUM_TYPES = 43;
    // Report queue depth
    localparam int ESN_QDEPTH = 16;
    localparam int ESN_QPTR_W = 4;
endpackage

// ===== esn_event_select_notify.sv
/*
 * Event select and notification: detects occurrences, gates each
 * type by its enable, queues reports to the host in order.
 * Assumes event sources on clk give one-cycle pulses; input lines
 * come from pins and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE1: Selector picks event type for enable setting
// RULE2: Disabled selected type is never reported
// RULE3: Enabled type reports every occurrence; a repeat while the type still waits merges and sets rpt_lost
// RULE4: Line rise raises rise event
// RULE5: Line fall raises fall event
// RULE6: Any line transition raises toggle event
// RULE7: Counter begin raises per-counter event
// RULE8: Counter finish raises per-counter event
// RULE9: Timer begin raises per-timer event
// RULE10: Timer finish raises per-timer event
// RULE11: Late scheduled command raises late event
// RULE12: Link rate change raises event
// RULE13: Transfer queue overflow raises event
// RULE14: Exposure begin raises event
// RULE15: Exposure finish raises event
// RULE16: Frame trigger accepted raises event
// RULE17: Frame begin and finish raise events
// RULE18: Burst begin and finish raise events
// RULE19: Acquisition begin and finish raise events
// RULE20: Error during acquisition raises fault event
// RULE21: Transfer suspend and continue raise events
// RULE22: Block trigger accepted raises event
// RULE23: Line edges judged after input inversion
// RULE24: All enables off after reset
// RULE25: Gated pulses queued in occurrence order; code queues the lowest pending code first, one per cycle
module esn_event_select_notify
    import esn_pkg::*;
#(
    parameter int QDEPTH = ESN_QDEPTH,
    parameter int QPTR_W = ESN_QPTR_W
)
(
    input wire logic clk,
    input wire logic rst_n,
    // Selector and enable access
    input wire logic sel_wr,
    input wire logic [ESN_SEL_W-1:0] sel_wdata,
    output logic [ESN_SEL_W-1:0] event_source_select,
    input wire logic en_wr,
    input wire logic en_wdata,
    output logic event_report_enable,
    // Input lines (pins) and their inversion controls
    input wire logic [1:0] line_pin,
    input wire logic [1:0] line_invert,
    // Internal occurrence pulses
    input wire logic acq_trig_evt,
    input wire logic acq_begin_evt,
    input wire logic acq_finish_evt,
    input wire logic acq_xfer_begin_evt,
    input wire logic acq_xfer_finish_evt,
    input wire logic acq_error_seen,
    input wire logic acq_active,
    input wire logic image_trig_received_evt,
    input wire logic image_capture_begin_evt,
    input wire logic image_capture_finish_evt,
    input wire logic burst_begin_evt,
    input wire logic burst_finish_evt,
    input wire logic image_xfer_begin_evt,
    input wire logic image_xfer_finish_evt,
    input wire logic expo_begin_evt,
    input wire logic expo_finish_evt,
    input wire logic xfer_begin_evt,
    input wire logic xfer_finish_evt,
    input wire logic xfer_suspend_evt,
    input wire logic xfer_continue_evt,
    input wire logic blk_begin_evt,
    input wire logic blk_finish_evt,
    input wire logic block_trig_received_evt,
    input wire logic xburst_begin_evt,
    input wire logic xburst_finish_evt,
    input wire logic xfer_queue_overflow_evt,
    input wire logic [1:0] cnt_begin_evt,
    input wire logic [1:0] cnt_finish_evt,
    input wire logic [1:0] tmr_begin_evt,
    input wire logic [1:0] tmr_finish_evt,
    input wire logic late_scheduled_cmd_evt,
    input wire logic link_rate_change_evt,
    input wire logic fault_evt,
    input wire logic controller_handover_evt,
    // Report stream toward the host
    output logic rpt_valid,
    output logic [ESN_SEL_W-1:0] rpt_code,
    input wire logic rpt_ready,
    output logic rpt_lost
);
    // ==========================================================
    // Line synchronisers and edge detection
    logic [1:0] line_s1_reg;
    logic [1:0] line_s2_reg;
    logic [1:0] line_prev_reg;
    logic line_primed_reg;
    logic [1:0] line_lvl;
    logic [1:0] line_rise;
    logic [1:0] line_fall;

    // Inverted synchronised level feeds the edge detect
    assign line_lvl = line_s2_reg ^ line_invert; // [RULE23]

    // Two-stage pin capture, previous level and priming flag
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_s1_reg <= 2'h0;
            line_s2_reg <= 2'h0;
            line_prev_reg <= 2'h0;
            line_primed_reg <= 1'b0;
        end
        else
        begin
            line_s1_reg <= line_pin;
            line_s2_reg <= line_s1_reg;
            line_prev_reg <= line_lvl;
            line_primed_reg <= 1'b1;
        end
    end

    assign line_rise = line_primed_reg ? (line_lvl & ~line_prev_reg) : 2'h0; // [RULE4]
    assign line_fall = line_primed_reg ? (~line_lvl & line_prev_reg) : 2'h0; // [RULE5]

    // ==========================================================
    // Occurrence vector indexed by event code
    logic [ESN_NUM_TYPES-1:0] occ;
    logic acq_fault_pulse;

    // Fault only counts while acquisition runs
    assign acq_fault_pulse = acq_error_seen & acq_active; // [RULE20]

    always_comb
    begin
        occ = '0;
        occ[EV_ACQ_TRIG] = acq_trig_evt;
        occ[EV_ACQ_BEGIN] = acq_begin_evt; // [RULE19]
        occ[EV_ACQ_FINISH] = acq_finish_evt; // [RULE19]
        occ[EV_ACQ_XFER_BEGIN] = acq_xfer_begin_evt;
        occ[EV_ACQ_XFER_FINISH] = acq_xfer_finish_evt;
        occ[EV_ACQ_FAULT] = acq_fault_pulse; // [RULE20]
        occ[EV_IMG_TRIG] = image_trig_received_evt; // [RULE16]
        occ[EV_IMG_BEGIN] = image_capture_begin_evt; // [RULE17]
        occ[EV_IMG_FINISH] = image_capture_finish_evt; // [RULE17]
        occ[EV_BURST_BEGIN] = burst_begin_evt; // [RULE18]
        occ[EV_BURST_FINISH] = burst_finish_evt; // [RULE18]
        occ[EV_IMG_XFER_BEGIN] = image_xfer_begin_evt;
        occ[EV_IMG_XFER_FINISH] = image_xfer_finish_evt;
        occ[EV_EXPO_BEGIN] = expo_begin_evt; // [RULE14]
        occ[EV_EXPO_FINISH] = expo_finish_evt; // [RULE15]
        occ[EV_XFER_BEGIN] = xfer_begin_evt;
        occ[EV_XFER_FINISH] = xfer_finish_evt;
        occ[EV_XFER_SUSPEND] = xfer_suspend_evt; // [RULE21]
        occ[EV_XFER_CONTINUE] = xfer_continue_evt; // [RULE21]
        occ[EV_BLK_BEGIN] = blk_begin_evt;
        occ[EV_BLK_FINISH] = blk_finish_evt;
        occ[EV_BLK_TRIG] = block_trig_received_evt; // [RULE22]
        occ[EV_XBURST_BEGIN] = xburst_begin_evt;
        occ[EV_XBURST_FINISH] = xburst_finish_evt;
        occ[EV_QUEUE_OVF] = xfer_queue_overflow_evt; // [RULE13]
        for (int u = 0; u < 2; u++)
        begin
            occ[EV_CNT_BEGIN0 + u] = cnt_begin_evt[u]; // [RULE7]
            occ[EV_CNT_FINISH0 + u] = cnt_finish_evt[u]; // [RULE8]
            occ[EV_TMR_BEGIN0 + u] = tmr_begin_evt[u]; // [RULE9]
            occ[EV_TMR_FINISH0 + u] = tmr_finish_evt[u]; // [RULE10]
            occ[EV_IN_RISE0 + u] = line_rise[u]; // [RULE4]
            occ[EV_IN_FALL0 + u] = line_fall[u]; // [RULE5]
            occ[EV_IN_TOGGLE0 + u] = line_rise[u] | line_fall[u]; // [RULE6]
        end
        occ[EV_LATE_CMD] = late_scheduled_cmd_evt; // [RULE11]
        occ[EV_LINK_RATE] = link_rate_change_evt; // [RULE12]
        occ[EV_FAULT] = fault_evt;
        occ[EV_HANDOVER] = controller_handover_evt;
    end

    // ==========================================================
    // Selector and per-type enables
    logic [ESN_SEL_W-1:0] sel_reg;
    logic [ESN_NUM_TYPES-1:0] en_reg;
    logic sel_in_range;
    logic [ESN_SEL_W-1:0] sel_next;
    logic [ESN_NUM_TYPES-1:0] en_next;

    assign sel_in_range = (sel_wdata < ESN_SEL_W'(ESN_NUM_TYPES));

    // Next selector (out-of-range codes ignored); enable write uses old selector
    assign sel_next = (sel_wr && sel_in_range) ? sel_wdata : sel_reg; // [RULE1]
    always_comb
    begin
        en_next = en_reg;
        if (en_wr)
            en_next[sel_reg] = en_wdata; // [RULE1]
    end

    // Selector, enables and registered view of the selected enable
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_reg <= 6'h00;
            en_reg <= '0; // [RULE24]
            event_report_enable <= 1'b0;
        end
        else
        begin
            sel_reg <= sel_next; // [RULE1]
            en_reg <= en_next;
            event_report_enable <= en_next[sel_next];
        end
    end

    assign event_source_select = sel_reg;

    // ==========================================================
    // Gating and pending bits, lowest code served first
    logic [ESN_NUM_TYPES-1:0] gated;
    logic [ESN_NUM_TYPES-1:0] pend_reg;
    logic [ESN_NUM_TYPES-1:0] pend_all;
    logic [ESN_NUM_TYPES-1:0] take_mask;
    logic [ESN_SEL_W-1:0] take_code;
    logic take_any;
    logic q_full;
    logic q_push;
    logic [ESN_NUM_TYPES-1:0] take_clr;

    assign gated = occ & en_reg; // [RULE2] [RULE3]
    assign pend_all = pend_reg | gated;

    // Pick one pending type per cycle
    always_comb
    begin
        take_mask = '0;
        take_code = 6'h00;
        take_any = 1'b0;
        for (int i = ESN_NUM_TYPES - 1; i >= 0; i--)
        begin
            if (pend_all[i])
            begin
                take_code = ESN_SEL_W'(i);
                take_any = 1'b1;
                take_mask = '0;
                take_mask[i] = 1'b1;
            end
        end
    end

    assign q_push = take_any && !q_full; // [RULE25]
    assign take_clr = q_push ? take_mask : '0;

    // Pending bits: a new pulse of the type queued now waits again (set wins),
    // a repeat of a type still waiting merges and is flagged
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_reg <= '0;
            rpt_lost <= 1'b0;
        end
        else
        begin
            pend_reg <= ((pend_all & ~take_clr) | (pend_reg & gated)) & en_next; // [RULE3]
            rpt_lost <= |(pend_reg & gated & ~take_clr);
        end
    end

    // ==========================================================
    // Report queue in order of push
    logic [ESN_SEL_W-1:0] q_mem [QDEPTH];
    logic [QPTR_W:0] wr_ptr_reg;
    logic [QPTR_W:0] rd_ptr_reg;
    logic q_pop;
    logic q_empty;

    assign q_empty = (wr_ptr_reg == rd_ptr_reg);
    assign q_full = (wr_ptr_reg[QPTR_W-1:0] == rd_ptr_reg[QPTR_W-1:0]) &&
                    (wr_ptr_reg[QPTR_W] != rd_ptr_reg[QPTR_W]);
    assign q_pop = !q_empty && (!rpt_valid || rpt_ready);

    always_ff @(posedge clk)
    begin
        if (q_push)
            q_mem[wr_ptr_reg[QPTR_W-1:0]] <= take_code; // [RULE25]
    end

    // Pointers and output register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            rpt_valid <= 1'b0;
            rpt_code <= 6'h00;
        end
        else
        begin
            if (q_push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (q_pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
                rpt_code <= q_mem[rd_ptr_reg[QPTR_W-1:0]];
                rpt_valid <= 1'b1;
            end
            else if (rpt_ready)
                rpt_valid <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    AST_RESET_OFF: assert property (@(posedge clk) $rose(rst_n) |-> en_reg == '0) // [RULE24]
        else $error("enables not off after reset");
    AST_SEL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        sel_wr && sel_in_range |=> event_source_select == $past(sel_wdata)) // [RULE1]
        else $error("selector write not taken");
    AST_NO_REPORT_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        q_push |-> en_reg[take_code]) // [RULE2]
        else $error("disabled type queued");
    AST_REPORT_ON: assert property (@(posedge clk) disable iff (!rst_n)
        gated != '0 |=> pend_reg != '0 || $past(q_push)) // [RULE3]
        else $error("enabled occurrence dropped");
    AST_RISE: assert property (@(posedge clk) disable iff (!rst_n)
        line_primed_reg && line_lvl[0] && !line_prev_reg[0] |-> occ[EV_IN_RISE0]) // [RULE4]
        else $error("rise on line 0 missed");
    AST_FALL: assert property (@(posedge clk) disable iff (!rst_n)
        line_primed_reg && !line_lvl[1] && line_prev_reg[1] |-> occ[EV_IN_FALL0 + 1]) // [RULE5]
        else $error("fall on line 1 missed");
    AST_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n)
        line_primed_reg && $changed(line_lvl[0]) |-> occ[EV_IN_TOGGLE0]) // [RULE6]
        else $error("toggle on line 0 missed");
    AST_INVERT: assert property (@(posedge clk) disable iff (!rst_n)
        line_primed_reg && $stable(line_s2_reg[0]) && $changed(line_invert[0])
        |-> occ[EV_IN_TOGGLE0]) // [RULE23]
        else $error("inversion change gave no edge");
    AST_FAULT_GATE: assert property (@(posedge clk) disable iff (!rst_n)
        occ[EV_ACQ_FAULT] |-> acq_active) // [RULE20]
        else $error("fault outside acquisition");
    AST_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
        q_pop |=> rpt_valid && rpt_code == $past(q_mem[rd_ptr_reg[QPTR_W-1:0]])) // [RULE25]
        else $error("queue order broken");
endmodule

`default_nettype wire

// ===== esn_host_model.sv
/*
 * Host side model for the event notify block: accepts reports and
 * keeps the received event codes in arrival order.
 * Assumes one clock shared with the block; bench drives stall.
 */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Report sink
module esn_host_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rpt_valid,
    input wire logic [5:0] rpt_code,
    output logic rpt_ready,
    input wire logic stall
);
    logic [5:0] got[$];

    // Ready unless held off
    assign rpt_ready = !stall;

    // Keep each accepted code
    always @(posedge clk)
    begin
        if (rst_n && rpt_valid && rpt_ready)
        begin
            got.push_back(rpt_code);
        end
    end
endmodule

`default_nettype wire

// ===== esn_event_select_notify_tb_top.sv
/*
 * Self-checking bench for the event notify block: selector and
 * enable writes, event pulses, line edges and report order.
 * Assumes the host model file is compiled before this one.
 */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bench top
module esn_event_select_notify_tb_top
    import esn_pkg::*;
;
    logic clk, rst_n, sel_wr, en_wr, en_wdata, act, stall;
    logic [ESN_SEL_W-1:0] sel_wdata, sel_q, rpt_code;
    logic en_q, rpt_valid, rpt_ready, rpt_lost;
    logic [1:0] pin, inv;
    logic [ESN_NUM_TYPES-1:0] ev;
    int error_cnt, comparisons;
    int cyc = 0;

    // Block and host
    esn_event_select_notify dut_u (.clk(clk), .rst_n(rst_n), .sel_wr(sel_wr),
        .sel_wdata(sel_wdata), .event_source_select(sel_q), .en_wr(en_wr),
        .en_wdata(en_wdata), .event_report_enable(en_q), .line_pin(pin), .line_invert(inv),
        .acq_trig_evt(ev[0]), .acq_begin_evt(ev[1]), .acq_finish_evt(ev[2]),
        .acq_xfer_begin_evt(ev[3]), .acq_xfer_finish_evt(ev[4]), .acq_error_seen(ev[5]),
        .acq_active(act), .image_trig_received_evt(ev[6]), .image_capture_begin_evt(ev[7]),
        .image_capture_finish_evt(ev[8]), .burst_begin_evt(ev[9]), .burst_finish_evt(ev[10]),
        .image_xfer_begin_evt(ev[11]), .image_xfer_finish_evt(ev[12]),
        .expo_begin_evt(ev[13]), .expo_finish_evt(ev[14]), .xfer_begin_evt(ev[15]),
        .xfer_finish_evt(ev[16]), .xfer_suspend_evt(ev[17]), .xfer_continue_evt(ev[18]),
        .blk_begin_evt(ev[19]), .blk_finish_evt(ev[20]), .block_trig_received_evt(ev[21]),
        .xburst_begin_evt(ev[22]), .xburst_finish_evt(ev[23]),
        .xfer_queue_overflow_evt(ev[24]), .cnt_begin_evt(ev[26:25]),
        .cnt_finish_evt(ev[28:27]), .tmr_begin_evt(ev[30:29]), .tmr_finish_evt(ev[32:31]),
        .late_scheduled_cmd_evt(ev[39]), .link_rate_change_evt(ev[40]), .fault_evt(ev[41]),
        .controller_handover_evt(ev[42]), .rpt_valid(rpt_valid), .rpt_code(rpt_code),
        .rpt_ready(rpt_ready), .rpt_lost(rpt_lost));
    esn_host_model host_u (.clk(clk), .rst_n(rst_n), .rpt_valid(rpt_valid),
        .rpt_code(rpt_code), .rpt_ready(rpt_ready), .stall(stall));

    // Clock and hang guard
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            error_cnt++;
            $display("ERROR at %0t: run too long", $time);
            complete_run();
        end
    end

    // ==========================================================
    // Access and compare tasks
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [5:0] a, input logic [5:0] b);
        comparisons++;
        if (a !== b)
        begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, a, b);
        end
    endtask
    task automatic wsel(input logic [5:0] c);
        sel_wr = 1;
        sel_wdata = c;
        tick(1);
        sel_wr = 0;
        tick(1);
    endtask
    task automatic wen(input logic v);
        en_wr = 1;
        en_wdata = v;
        tick(1);
        en_wr = 0;
        tick(1);
    endtask
    task automatic seten(input logic [5:0] c, input logic v);
        wsel(c);
        wen(v);
        chk({5'h00, en_q}, {5'h00, v});
    endtask
    task automatic fire(input logic [ESN_NUM_TYPES-1:0] m);
        ev = m;
        tick(1);
        ev = '0;
        tick(1);
    endtask
    task automatic want(input logic [5:0] c);
        int n;
        n = 0;
        while (host_u.got.size() == 0 && n < 30)
        begin
            tick(1);
            n++;
        end
        if (host_u.got.size() == 0)
        begin
            comparisons++;
            error_cnt++;
            $display("ERROR at %0t: no report of %h", $time, c);
        end
        else
            chk(host_u.got.pop_front(), c);
    endtask
    task automatic none();
        tick(6);
        comparisons++;
        if (host_u.got.size() != 0)
        begin
            error_cnt++;
            $display("ERROR at %0t: unexpected report", $time);
            host_u.got.delete();
        end
    endtask
    task automatic epair(input logic [5:0] b, input int l);
        want(6'(b + l));
        want(6'(EV_IN_TOGGLE0 + l));
    endtask
    task automatic complete_run();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ==========================================================
    // Test sequence
    initial
    begin
        {rst_n, sel_wr, en_wr, en_wdata, stall, pin, inv, ev} = '0;
        sel_wdata = '0;
        act = 1;
        error_cnt = 0;
        comparisons = 0;
        tick(3);
        rst_n = 1;
        tick(1);
        chk({5'h00, rpt_valid}, 6'h00);
        // Every type off by default; all but line codes 33 to 38 silent when off, reported when on
        for (int c = 0; c < ESN_NUM_TYPES; c++)
        begin
            wsel(c[5:0]);
            chk(sel_q, c[5:0]);
            chk({5'h00, en_q}, 6'h00);
            if (c < 33 || c > 38)
            begin
                fire(43'h1 << c);
                none();
                wen(1);
                chk({5'h00, en_q}, 6'h01);
                fire(43'h1 << c);
                want(c[5:0]);
                wen(0);
            end
        end
        $display("test type_sweep done");
        // Fault only while acquiring
        seten(EV_ACQ_FAULT, 1);
        act = 0;
        fire(43'h1 << 5);
        none();
        act = 1;
        fire(43'h1 << 5);
        want(EV_ACQ_FAULT);
        seten(EV_ACQ_FAULT, 0);
        $display("test fault_gate done");
        // Simultaneous events under host stall
        seten(EV_ACQ_FINISH, 1);
        seten(EV_EXPO_FINISH, 1);
        seten(EV_LINK_RATE, 1);
        stall = 1;
        ev = (43'h1 << 2) | (43'h1 << 14) | (43'h1 << 40);
        tick(1);
        ev = (43'h1 << 14) | (43'h1 << 40);
        tick(1);
        chk({5'h00, rpt_lost}, 6'h01);
        ev = '0;
        tick(8);
        chk({5'h00, rpt_lost}, 6'h00);
        chk({5'h00, rpt_valid}, 6'h01);
        chk(rpt_code, EV_ACQ_FINISH);
        stall = 0;
        want(EV_ACQ_FINISH);
        want(EV_EXPO_FINISH);
        want(EV_EXPO_FINISH);
        want(EV_LINK_RATE);
        none();
        wsel(6'h3f);
        chk(sel_q, EV_LINK_RATE);
        seten(EV_ACQ_FINISH, 0);
        seten(EV_EXPO_FINISH, 0);
        seten(EV_LINK_RATE, 0);
        $display("test order_stall done");
        // Line edges, raw and inverted
        for (int l = 0; l < 2; l++)
        begin
            for (int k = 0; k < 3; k++)
                seten(6'(EV_IN_RISE0 + 2 * k + l), 1);
            pin[l] = 1;
            epair(EV_IN_RISE0, l);
            pin[l] = 0;
            epair(EV_IN_FALL0, l);
            inv[l] = 1;
            epair(EV_IN_RISE0, l);
            pin[l] = 1;
            epair(EV_IN_FALL0, l);
            inv[l] = 0;
            epair(EV_IN_RISE0, l);
            pin[l] = 0;
            epair(EV_IN_FALL0, l);
            for (int k = 0; k < 3; k++)
                seten(6'(EV_IN_RISE0 + 2 * k + l), 0);
        end
        $display("test line_edges done");
        // Reset in mid-run clears selector and enables
        seten(EV_LATE_CMD, 1);
        rst_n = 0;
        tick(1);
        rst_n = 1;
        tick(1);
        chk(sel_q, 6'h00);
        wsel(EV_LATE_CMD);
        chk({5'h00, en_q}, 6'h00);
        fire(43'h1 << 39);
        none();
        $display("test mid_reset done");
        complete_run();
    end
endmodule

`default_nettype wire
